// *** verilog/uhirq_cfg.svh ***
// uhirq_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the register block by bare name
`ifndef UHIRQ_CFG_SVH
`define UHIRQ_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UHIRQ_OFF_STATUS     12'h404
`define UHIRQ_OFF_CLEAR      12'h408
`define UHIRQ_OFF_FORCE      12'h40C
`define UHIRQ_OFF_ENABLE     12'h410
`define UHIRQ_OFF_EN_CLEAR   12'h414
`define UHIRQ_OFF_EN_SET     12'h418
`define UHIRQ_OFF_FRAME      12'h420

// ----------------------------------------
// field layout
// ----------------------------------------
`define UHIRQ_EVT_LSB        0
`define UHIRQ_EVT_W          7
`define UHIRQ_PIPE_LSB       8
`define UHIRQ_DMA_LSB        25
`define UHIRQ_ATTACH_BIT     0
`define UHIRQ_SOF_BIT        5
`define UHIRQ_FIDX_LSB       3
`define UHIRQ_FIDX_W         11
`define UHIRQ_FLEN_LSB       16
`define UHIRQ_FLEN_W         8

// ----------------------------------------
// reset values and frame timing
// ----------------------------------------
`define UHIRQ_RST_WORD       32'h00000000
`define UHIRQ_FRAME_TICKS    14'd12000
`define UHIRQ_TICK_HZ        12000000
`define UHIRQ_CLK_HZ         50000000

`endif

// *** verilog/uhirq_pkg.sv ***
// uhirq_pkg.sv: types shared by the host interrupt register block
// assumes: the cfg header sits on the include path
package uhirq_pkg;
    `include "uhirq_cfg.svh"
    // ----------------------------------------
    // bus transfer encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        UHIRQ_IDLE   = 2'h0,
        UHIRQ_BUSY   = 2'h1,
        UHIRQ_NONSEQ = 2'h2,
        UHIRQ_SEQ    = 2'h3
    } uhirq_trans_t;
    typedef logic [31:0] uhirq_word_t;
endpackage

// *** verilog/uhirq_regs.sv ***
// uhirq_regs.sv: host interrupt flags, enables and frame number register
// assumes: one AHB-Lite master, event pulses synchronous to hclk
`timescale 1ns/1ns
`default_nettype none
`include "uhirq_cfg.svh"

// Function
// [R1] attach event raises attach flag
// [R2] only attach-clear write drops attach flag
// [R3] clear register drops flags written one; the code drops only event flags 0..6
// [R4] force register sets flags incl. dma
// [R5] dma enables set/clear by written ones
// [R6] pipe enables set/clear, gate pipe flags
// [R7] wake-up enable set/clear by ones
// [R8] frame-start enable set/clear by ones
// [R9] resume-received enable set/clear by ones
// [R10] resume-sent enable set/clear by ones
// [R11] reset-sent enable set/clear by ones
// [R12] detach enable set/clear by ones
// [R13] attach enable, enable register read-only
// [R14] enable-clear register clears enables
// [R15] enable-set register sets enables
// [R16] irq when flag and enable both one
// [R17] frame index readable and writable
// [R18] frame length high from 14-bit counter
// [R19] write-only registers read zero
// [R20] frame register field positions
module uhirq_regs #(
    parameter int NUM_PIPES = 7,                 // pipe flags 0..6
    parameter int NUM_DMA   = 6                  // dma flags 1..6
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire uhirq_pkg::uhirq_trans_t htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // event pulses from the host core
    input  wire logic [6:0]            evt_pulse,
    input  wire logic [NUM_PIPES-1:0]  pipe_evt,
    input  wire logic [NUM_DMA-1:0]    dma_evt,
    // interrupt request and status view
    output logic                       usb_irq,
    output logic [31:0]                host_irq_status
);
    import uhirq_pkg::*;

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    // refused at elaboration: the status word has room for 7 pipes and 6 channels only
    if (NUM_PIPES < 1 || NUM_PIPES > 7 || NUM_DMA < 1 || NUM_DMA > 6) begin : g_bad_count
        $error("uhirq_regs: unsupported pipe or dma count");
    end

    localparam logic [31:0] PIPE_MASK = ((32'h1 << NUM_PIPES) - 32'h1) << `UHIRQ_PIPE_LSB;
    localparam logic [31:0] DMA_MASK  = ((32'h1 << NUM_DMA) - 32'h1) << `UHIRQ_DMA_LSB;
    localparam logic [31:0] EVT_MASK  = 32'h0000007F;
    localparam logic [31:0] FLAG_MASK = EVT_MASK | PIPE_MASK | DMA_MASK;
    // pipe flags follow their sources only, so the force register cannot reach them
    localparam logic [31:0] FRC_MASK  = EVT_MASK | DMA_MASK;
    // 12 MHz tick from 50 MHz by phase accumulator, exact on average
    localparam logic [25:0] TICK_STEP = 26'(`UHIRQ_TICK_HZ / 4000);
    localparam logic [25:0] TICK_WRAP = 26'(`UHIRQ_CLK_HZ / 4000);

    // ----------------------------------------
    // bus address phase capture
    // ----------------------------------------
    // reads answer from the address phase, so only writes use the latched address
    logic        dp_wr;          // write data phase pending
    logic [11:0] dp_addr;        // latched address

    // every transfer answers in zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // latch write address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            dp_wr   <= hsel && htrans[1] && hwrite;
            dp_addr <= haddr;
        end
    end

    // one-cycle write strobes, decoded once per register
    // gated by hready so a stretched data phase would still act only once
    function automatic logic wr_hit(input logic [11:0] off);
        return dp_wr && hready && (dp_addr == off);
    endfunction

    logic [31:0] clr_w, frc_w, enc_w, ens_w;
    assign clr_w = wr_hit(`UHIRQ_OFF_CLEAR)    ? (hwdata & EVT_MASK)  : 32'h00000000; // [R3]
    assign frc_w = wr_hit(`UHIRQ_OFF_FORCE)    ? (hwdata & FRC_MASK)  : 32'h00000000; // [R4]
    assign enc_w = wr_hit(`UHIRQ_OFF_EN_CLEAR) ? (hwdata & FLAG_MASK) : 32'h00000000; // [R14]
    assign ens_w = wr_hit(`UHIRQ_OFF_EN_SET)   ? (hwdata & FLAG_MASK) : 32'h00000000; // [R15]

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // core pulses land in their status positions, unmapped bits are dropped
    logic [31:0] hw_set;         // hardware event vector
    assign hw_set = ((32'(evt_pulse)) | (32'(pipe_evt) << `UHIRQ_PIPE_LSB)
                    | (32'(dma_evt) << `UHIRQ_DMA_LSB)) & FLAG_MASK;

    // set wins over clear so no event is lost; pipe and dma flags follow
    // their own sources and are not cleared through the clear register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            host_irq_status <= `UHIRQ_RST_WORD;
        else
            host_irq_status <= (host_irq_status & ~clr_w) | hw_set | frc_w; // [R1] [R2] [R3] [R4]
    end

    // ----------------------------------------
    // enable register
    // ----------------------------------------
    // changed only through the set and clear registers, never written directly
    logic [31:0] irq_enable;     // software view, read-only

    // set wins if one write could carry both; writes are separate registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_enable <= `UHIRQ_RST_WORD;
        else
            irq_enable <= (irq_enable & ~enc_w) | ens_w; // [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13]
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    // registered so the line never glitches; costs one cycle of latency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            usb_irq <= 1'b0;
        else
            usb_irq <= |(host_irq_status & irq_enable); // [R16]
    end

    // ----------------------------------------
    // frame counter and index
    // ----------------------------------------
    logic [25:0] tick_acc;       // 12 MHz phase accumulator
    logic        tick;           // one-cycle 12 MHz enable
    logic [13:0] frame_cnt;      // 12000-step frame counter
    logic [10:0] frame_index;    // current frame number
    logic        sof_pulse;      // frame start

    // combinational tick keeps accumulator and frame counter on the same edge
    assign tick = (tick_acc + TICK_STEP) >= TICK_WRAP;
    assign sof_pulse = tick && (frame_cnt == `UHIRQ_FRAME_TICKS - 14'd1);

    // fractional divider keeps the average rate exact
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            tick_acc <= 26'h0000000;
        else if (tick)
            tick_acc <= tick_acc + TICK_STEP - TICK_WRAP;
        else
            tick_acc <= tick_acc + TICK_STEP;
    end

    // frame length counter, wraps every 1 ms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            frame_cnt <= 14'h0000;
        else if (sof_pulse)
            frame_cnt <= 14'h0000;
        else if (tick)
            frame_cnt <= frame_cnt + 14'd1; // [R18]
    end

    // frame index: software write wins over the increment
    // the 11-bit index wraps after 2048 frames, like the field it feeds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            frame_index <= 11'h000;
        else if (wr_hit(`UHIRQ_OFF_FRAME))
            frame_index <= hwdata[`UHIRQ_FIDX_LSB +: `UHIRQ_FIDX_W]; // [R17]
        else if (sof_pulse)
            frame_index <= frame_index + 11'd1; // [R17]
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] frame_word;
    assign frame_word = {8'h00, frame_cnt[13:6], 2'b00, frame_index, 3'b000}; // [R18] [R20]

    // registered read data, captured at the address phase
    // limitation: a read issued during a write's data phase sees the older value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
                `UHIRQ_OFF_STATUS: hrdata <= host_irq_status;
                `UHIRQ_OFF_ENABLE: hrdata <= irq_enable;
                `UHIRQ_OFF_FRAME:  hrdata <= frame_word;
                default:           hrdata <= 32'h00000000; // [R19]
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_attach_set;
        @(posedge hclk) disable iff (!hresetn)
        evt_pulse[0] |=> host_irq_status[0];
    endproperty
    a_attach_set: assert property (p_attach_set) else $error("attach flag not raised"); // [R1]

    property p_attach_hold;
        @(posedge hclk) disable iff (!hresetn)
        host_irq_status[0] && !clr_w[0] |=> host_irq_status[0];
    endproperty
    a_attach_hold: assert property (p_attach_hold) else $error("attach flag lost"); // [R2]

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        clr_w[2] && !hw_set[2] && !frc_w[2] |=> !host_irq_status[2];
    endproperty
    a_clear: assert property (p_clear) else $error("flag clear failed"); // [R3]

    property p_force;
        @(posedge hclk) disable iff (!hresetn)
        frc_w[`UHIRQ_DMA_LSB] |=> host_irq_status[`UHIRQ_DMA_LSB];
    endproperty
    a_force: assert property (p_force) else $error("dma flag force failed"); // [R4]

    property p_en_set;
        @(posedge hclk) disable iff (!hresetn)
        ens_w[`UHIRQ_PIPE_LSB] |=> irq_enable[`UHIRQ_PIPE_LSB];
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set failed"); // [R15]

    property p_en_clr;
        @(posedge hclk) disable iff (!hresetn)
        enc_w[`UHIRQ_SOF_BIT] && !ens_w[`UHIRQ_SOF_BIT] |=> !irq_enable[`UHIRQ_SOF_BIT];
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable clear failed"); // [R14]

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        ##1 usb_irq == |($past(host_irq_status) & $past(irq_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow flags"); // [R16]

    property p_wo_read;
        @(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans[1] && !hwrite && haddr == `UHIRQ_OFF_EN_SET |=> hrdata == 32'h00000000;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only read nonzero"); // [R19]

    property p_fidx_write;
        @(posedge hclk) disable iff (!hresetn)
        dp_wr && hready && dp_addr == `UHIRQ_OFF_FRAME |=> frame_index == $past(hwdata[13:3]);
    endproperty
    a_fidx_write: assert property (p_fidx_write) else $error("frame index write lost"); // [R17]

    property p_frame_bound;
        @(posedge hclk) disable iff (!hresetn)
        frame_cnt < `UHIRQ_FRAME_TICKS;
    endproperty
    a_frame_bound: assert property (p_frame_bound) else $error("frame counter overrun"); // [R18]

    property p_layout;
        @(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans[1] && !hwrite && haddr == `UHIRQ_OFF_FRAME |=>
            hrdata[2:0] == 3'b000 && hrdata[15:14] == 2'b00 && hrdata[31:24] == 8'h00;
    endproperty
    a_layout: assert property (p_layout) else $error("frame reserved bits set"); // [R20]

    // every event must show in the flags one cycle on
    property p_set_all;
        @(posedge hclk) disable iff (!hresetn)
        hw_set != 32'h00000000 |=> (host_irq_status & $past(hw_set)) == $past(hw_set);
    endproperty
    a_set_all: assert property (p_set_all) else $error("event flag not raised"); // [R1]

    property p_attach_clr;
        @(posedge hclk) disable iff (!hresetn)
        clr_w[`UHIRQ_ATTACH_BIT] && !hw_set[`UHIRQ_ATTACH_BIT] |=> !host_irq_status[`UHIRQ_ATTACH_BIT];
    endproperty
    a_attach_clr: assert property (p_attach_clr) else $error("attach flag not cleared"); // [R2]

    property p_no_drop;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ($past(host_irq_status) & ~$past(clr_w) & ~host_irq_status) == 32'h00000000;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("flag dropped without clear"); // [R3]

    property p_force_all;
        @(posedge hclk) disable iff (!hresetn)
        frc_w != 32'h00000000 |=> (host_irq_status & $past(frc_w)) == $past(frc_w);
    endproperty
    a_force_all: assert property (p_force_all) else $error("forced flag not set"); // [R4]

    property p_force_pipe;
        @(posedge hclk) disable iff (!hresetn)
        dp_wr && hready && dp_addr == `UHIRQ_OFF_FORCE && hw_set == 32'h00000000 |=>
            (host_irq_status & PIPE_MASK) == ($past(host_irq_status) & PIPE_MASK);
    endproperty
    a_force_pipe: assert property (p_force_pipe) else $error("force reached pipe flags"); // [R4]

    property p_dma_en;
        @(posedge hclk) disable iff (!hresetn)
        ens_w[`UHIRQ_DMA_LSB] |=> irq_enable[`UHIRQ_DMA_LSB];
    endproperty
    a_dma_en: assert property (p_dma_en) else $error("dma enable not set"); // [R5]

    property p_pipe_gate;
        @(posedge hclk) disable iff (!hresetn)
        host_irq_status[`UHIRQ_PIPE_LSB] && irq_enable[`UHIRQ_PIPE_LSB] |=> usb_irq;
    endproperty
    a_pipe_gate: assert property (p_pipe_gate) else $error("enabled pipe flag gave no irq"); // [R6]

    property p_en_keep;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ((irq_enable ^ $past(irq_enable)) & ~($past(enc_w) | $past(ens_w))) == 32'h00000000;
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("enable changed without write"); // [R13]

    property p_en_set_all;
        @(posedge hclk) disable iff (!hresetn)
        ens_w != 32'h00000000 |=> (irq_enable & $past(ens_w)) == $past(ens_w);
    endproperty
    a_en_set_all: assert property (p_en_set_all) else $error("enable bits not set"); // [R15]

    property p_en_clr_all;
        @(posedge hclk) disable iff (!hresetn)
        enc_w != 32'h00000000 && ens_w == 32'h00000000 |=> (irq_enable & $past(enc_w)) == 32'h00000000;
    endproperty
    a_en_clr_all: assert property (p_en_clr_all) else $error("enable bits not cleared"); // [R14]

    property p_irq_low;
        @(posedge hclk) disable iff (!hresetn)
        (host_irq_status & irq_enable) == 32'h00000000 |=> !usb_irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without enabled flag"); // [R16]

    property p_wo_read_all;
        @(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans[1] && !hwrite &&
            (haddr == `UHIRQ_OFF_CLEAR || haddr == `UHIRQ_OFF_FORCE || haddr == `UHIRQ_OFF_EN_CLEAR)
            |=> hrdata == 32'h00000000;
    endproperty
    a_wo_read_all: assert property (p_wo_read_all) else $error("write-only read nonzero"); // [R19]

    property p_fidx_inc;
        @(posedge hclk) disable iff (!hresetn)
        sof_pulse && !(dp_wr && hready && dp_addr == `UHIRQ_OFF_FRAME) |=>
            frame_index == $past(frame_index) + 11'd1;
    endproperty
    a_fidx_inc: assert property (p_fidx_inc) else $error("frame index did not step"); // [R17]

    property p_sof_wrap;
        @(posedge hclk) disable iff (!hresetn)
        sof_pulse |=> frame_cnt == 14'h0000;
    endproperty
    a_sof_wrap: assert property (p_sof_wrap) else $error("frame counter did not wrap"); // [R18]

    property p_tick_gap;
        @(posedge hclk) disable iff (!hresetn)
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("12 MHz tick too fast"); // [R18]
endmodule
`default_nettype wire

// *** verification/uhirq_dev_model.sv ***
// uhirq_dev_model.sv: event source standing in for the attached device and host core
// assumes: one hclk domain, the bench calls pulse() right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module uhirq_dev_model (
    // clock
    input  wire logic       hclk,
    // event pulses toward the block
    output logic [6:0]      evt_pulse,
    output logic [6:0]      pipe_evt,
    output logic [5:0]      dma_evt
);
    // ----------------------------------------
    // idle lines, then one-cycle pulses
    // ----------------------------------------
    initial begin
        evt_pulse = 7'h00;  // quiet until a device acts
        pipe_evt  = 7'h00;
        dma_evt   = 6'h00;
    end
    // pulse lasts exactly one cycle, a longer one would hide a clear
    task automatic pulse(input logic [6:0] e, input logic [6:0] p, input logic [5:0] d);
        @(posedge hclk);
        evt_pulse <= e;
        pipe_evt  <= p;
        dma_evt   <= d;
        @(posedge hclk);
        evt_pulse <= 7'h00;
        pipe_evt  <= 7'h00;
        dma_evt   <= 6'h00;
    endtask
endmodule
`default_nettype wire

// *** verification/uhirq_regs_tb.sv ***
// uhirq_regs_tb.sv: self-checking bench for the host interrupt register block
// assumes: zero-wait slave, hready fed back from hreadyout, model in the bench
`timescale 1ns/1ns
`default_nettype none
`include "uhirq_cfg.svh"
module uhirq_regs_tb;
    import uhirq_pkg::*;
    localparam logic [31:0] EN_MASK  = 32'h7E007F7F;  // implemented enable bits
    localparam logic [31:0] FRC_MASK = 32'h7E00007F;  // forceable flags
    logic              hclk    = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel    = 1'b0;
    logic [11:0]       haddr   = 12'h000;
    uhirq_trans_t      htrans  = UHIRQ_IDLE;
    logic              hwrite  = 1'b0;
    logic [31:0]       hwdata  = 32'h00000000;
    wire logic [31:0]  hrdata;
    wire logic         hreadyout;
    wire logic         hresp;
    wire logic         usb_irq;
    wire logic [31:0]  host_irq_status;
    wire logic [6:0]   evt_pulse;
    wire logic [6:0]   pipe_evt;
    wire logic [5:0]   dma_evt;
    logic [31:0]       seed = 32'hE9809E84;  // fixed start of the xorshift
    logic [31:0]       m_st = 32'h00000000;  // model of the flags
    logic [31:0]       m_en = 32'h00000000;  // model of the enables
    logic [31:0]       r;
    logic [31:0]       fw;                   // frame word last written
    int                err_total = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                e;
    logic [11:0]       wo [5] = '{`UHIRQ_OFF_CLEAR, `UHIRQ_OFF_FORCE, `UHIRQ_OFF_EN_CLEAR, `UHIRQ_OFF_EN_SET, 12'h500};

    always #10 hclk = ~hclk;  // 50 MHz
    always @(posedge hclk) if (hresetn) cyc <= cyc + 1;  // cycles since release

    uhirq_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .evt_pulse(evt_pulse), .pipe_evt(pipe_evt),
        .dma_evt(dma_evt), .usb_irq(usb_irq), .host_irq_status(host_irq_status));
    uhirq_dev_model dev (.hclk(hclk), .evt_pulse(evt_pulse), .pipe_evt(pipe_evt), .dma_evt(dma_evt));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // bounded wait for hready at a rising edge, a hang ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                $display("Error at %0t: bus never ready", $time);
                conclude();
            end
            @(posedge hclk);
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= UHIRQ_NONSEQ;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= UHIRQ_IDLE;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] q;
        xfer(1'b0, a, 32'h00000000, q);
        chk(q & msk, exp & msk, "register read");
        chk({31'h0, hresp}, 32'h0, "bus response");
    endtask
    // compare flags, enables and the request line with the model
    task automatic sync();
        rd_chk(`UHIRQ_OFF_STATUS, m_st, 32'hFFFFFFFF);
        rd_chk(`UHIRQ_OFF_ENABLE, m_en, 32'hFFFFFFFF);
        chk(host_irq_status, m_st, "status port");
        chk({31'h0, usb_irq}, {31'h0, |(m_st & m_en)}, "irq");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        sync();
        rd_chk(`UHIRQ_OFF_FRAME, 32'h0, 32'hFF00FFFF);
        $display("test reset done");
        // attach flag survives clear bits 1..6
        dev.pulse(7'h01, 7'h00, 6'h00);
        m_st[0] = 1'b1;
        sync();
        wr(`UHIRQ_OFF_CLEAR, 32'h0000007E);
        sync();
        wr(`UHIRQ_OFF_CLEAR, 32'h00000001);
        m_st[0] = 1'b0;
        sync();
        r = rnd();
        dev.pulse(r[6:0], r[14:8], r[30:25]);
        m_st = m_st | (r & 32'h7E007F7F);
        sync();
        $display("test events done");
        repeat (6) begin
            r = rnd();
            wr(`UHIRQ_OFF_FORCE, r);
            m_st = m_st | (r & FRC_MASK);
            r = rnd();
            wr(`UHIRQ_OFF_CLEAR, r);
            m_st = m_st & ~(r & 32'h0000007F);
            sync();
        end
        $display("test flags done");
        wr(`UHIRQ_OFF_FORCE, FRC_MASK);
        m_st = m_st | FRC_MASK;
        for (int i = 0; i < 32; i++) begin
            if (EN_MASK[i]) begin
                wr(`UHIRQ_OFF_EN_SET, 32'h1 << i);
                m_en[i] = 1'b1;
                sync();
                wr(`UHIRQ_OFF_EN_CLEAR, 32'h1 << i);
                m_en[i] = 1'b0;
                sync();
            end
        end
        repeat (6) begin
            r = rnd();
            wr(`UHIRQ_OFF_EN_SET, r);
            m_en = m_en | (r & EN_MASK);
            wr(`UHIRQ_OFF_ENABLE, rnd());
            r = rnd();
            wr(`UHIRQ_OFF_EN_CLEAR, r);
            m_en = m_en & ~r;
            sync();
        end
        $display("test enables done");
        foreach (wo[i]) rd_chk(wo[i], 32'h0, 32'hFFFFFFFF);
        $display("test write-only reads done");
        r = rnd();
        fw = r;
        wr(`UHIRQ_OFF_FRAME, r);
        rd_chk(`UHIRQ_OFF_FRAME, r & 32'h00003FF8, 32'hFF00FFFF);
        repeat (1500) @(posedge hclk);
        xfer(1'b0, `UHIRQ_OFF_FRAME, 32'h0, r);
        e = (((cyc * 12) / 50) % 12000) >> 6;
        chk({31'h0, (r[23:16] + 8'h01 >= e[7:0]) && (r[23:16] <= e[7:0] + 8'h01)}, 32'h1, "frame length");
        // one frame start falls near cycle 50000 and must step the index once
        repeat (50500 - cyc) @(posedge hclk);
        xfer(1'b0, `UHIRQ_OFF_FRAME, 32'h0, r);
        chk(r & 32'h00003FF8, (fw + 32'h00000008) & 32'h00003FF8, "frame index step");
        $display("test frame done");
        conclude();
    end
endmodule
`default_nettype wire
